// [motion_tap_orient_engine.sv]
// Summary of operation
// - motion event marks exactly one first axis
// - motion sign held until next trigger
// - knock when any axis slope exceeds threshold
// - single/double knock enable bits and status
// - threshold LSB 62.5mg at 2g, scales with range
// - shock/quiet both kinds, gap double only
// - slopes ignored during shock window
// - slope during quiet cancels pending event
// - single after shock+quiet, clears 12.5 ms later
// - double on second event within gap
// - shock bit: 50 ms or 75 ms
// - quiet bit: 30 ms or 20 ms
// - gap code maps 50 to 700 ms
// - first knock sign kept after clear
// - one-hot knock axis, cleared with status
// - low power evaluates 2/4/8/16 samples
// - mode field selects orientation classification
// - symmetrical quadrant conditions with hysteresis
// - high-asymmetrical doubles abs x
// - orientation code kept while sleeping
// - low-asymmetrical halves abs x
// - hysteresis LSB 62.5 mg in every range
// - code top bit is z sign
// - orientation interrupt on code change
`include "motion_tap_orient_regs.svh"
module motion_tap_orient_engine #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire motion_tap_orient_pkg::sample_t i_smp,
  input wire motion_tap_orient_pkg::motion_t i_mot,
  input wire logic [1:0] i_range,
  input wire logic i_lp_mode,
  input wire logic i_wake,
  output logic o_motion_int,
  output logic o_stap_int,
  output logic o_dtap_int,
  output logic o_orient_int
);
  import motion_tap_orient_pkg::*;

  logic wait_r;
  logic [7:0] feat_r;
  logic [7:0] ttime_r;
  logic [7:0] tthr_r;
  logic [7:0] ocfg_r;
  logic [14:0] tick_cnt_r;
  logic tick_r;
  tap_st_t st_r;
  tap_st_t st_nxt;
  logic [10:0] win_r;
  logic [2:0] pend_axis_r;
  logic pend_neg_r;
  logic [2:0] tfirst_r;
  logic tsign_r;
  logic stap_r;
  logic dtap_r;
  logic [4:0] stmr_r;
  logic [4:0] dtmr_r;
  logic mot_r;
  logic [2:0] mfirst_r;
  logic msign_r;
  logic [2:0] ori_r;
  logic ori_int_r;
  logic [4:0] samp_cnt_r;
  logic win_clr;
  logic s_fire;
  logic d_fire;
  logic cap;

  // bus decode
  wire [7:0] idx = i_avs_address[9:2];
  wire go = (i_avs_read | i_avs_write) & ~wait_r;
  wire wr_go = go & i_avs_write & i_avs_byteenable[0];
  wire [7:0] wd = i_avs_writedata[7:0];
  wire [7:0] stat = 8'(({7'h00, mot_r} << `ST_MOT)
    | ({7'h00, dtap_r} << `ST_DTAP) | ({7'h00, stap_r} << `ST_STAP)
    | ({7'h00, ori_int_r} << `ST_ORI));
  wire [7:0] detail = {tsign_r, tfirst_r, msign_r, mfirst_r};
  wire [7:0] rmux =
    (idx == `REG_STATUS) ? stat :
    (idx == `REG_DETAIL) ? detail :
    (idx == `REG_ORIENT) ? {5'h00, ori_r} :
    (idx == `REG_FEAT) ? feat_r :
    (idx == `REG_TTIME) ? ttime_r :
    (idx == `REG_TTHR) ? tthr_r :
    (idx == `REG_OCFG) ? ocfg_r : 8'h00;

  // answer one cycle after the request is seen, then rearm
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wait_r <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      wait_r <= ~((i_avs_read | i_avs_write) & wait_r);
      if ((i_avs_read | i_avs_write) & wait_r)
        o_avs_readdata <= {24'h000000, rmux};
    end
  end
  assign o_avs_waitrequest = wait_r;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      feat_r <= `RST_FEAT;
      ttime_r <= `RST_TTIME;
      tthr_r <= `RST_TTHR;
      ocfg_r <= `RST_OCFG;
    end
    else if (wr_go)
    begin
      if (idx == `REG_FEAT)
        feat_r <= wd;
      if (idx == `REG_TTIME)
        ttime_r <= wd;
      if (idx == `REG_TTHR)
        tthr_r <= wd;
      if (idx == `REG_OCFG)
        ocfg_r <= wd;
    end
  end

  // fixed time base, independent of filter bandwidth
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tick_cnt_r <= 15'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == 15'(TICK_CYC - 1));
      if (tick_cnt_r == 15'(TICK_CYC - 1))
        tick_cnt_r <= 15'h0;
      else
        tick_cnt_r <= tick_cnt_r + 15'h1;
    end
  end

  wire s_en = feat_r[`FE_STAP];
  wire d_en = feat_r[`FE_DTAP];
  wire [10:0] shock_tk = ttime_r[`TT_SHOCK] ? 11'(`MS2TK(`SHOCK1_MS))
                                            : 11'(`MS2TK(`SHOCK0_MS));
  wire [10:0] quiet_tk = ttime_r[`TT_QUIET] ? 11'(`MS2TK(`QUIET1_MS))
                                            : 11'(`MS2TK(`QUIET0_MS));

  function automatic logic [10:0] dur_tk(input logic [2:0] c);
    case (c)
      3'h0: dur_tk = 11'(`MS2TK(`DUR0_MS));
      3'h1: dur_tk = 11'(`MS2TK(`DUR1_MS));
      3'h2: dur_tk = 11'(`MS2TK(`DUR2_MS));
      3'h3: dur_tk = 11'(`MS2TK(`DUR3_MS));
      3'h4: dur_tk = 11'(`MS2TK(`DUR4_MS));
      3'h5: dur_tk = 11'(`MS2TK(`DUR5_MS));
      3'h6: dur_tk = 11'(`MS2TK(`DUR6_MS));
      default: dur_tk = 11'(`MS2TK(`DUR7_MS));
    endcase
  endfunction : dur_tk
  wire [10:0] gap_tk = dur_tk(ttime_r[`TT_DUR +: 3]);

  // slope data counts scale with range just as the threshold LSB does,
  // so a fixed shift gives the programmed threshold in every range
  wire [12:0] thr = {tthr_r[`TH_LVL +: 5], 8'h00};
  wire signed [13:0] slp [3];
  wire [2:0] over;
  assign slp[0] = i_smp.sx;
  assign slp[1] = i_smp.sy;
  assign slp[2] = i_smp.sz;
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_axis
      wire [13:0] mag = slp[g][13] ? 14'(-slp[g]) : 14'(slp[g]);
      assign over[g] = mag > {1'b0, thr};
    end
  endgenerate

  // low power: only the first N samples after a wake-up count
  wire [4:0] samp_n = 5'(5'h02 << tthr_r[`TH_SAMP +: 2]);
  wire lp_ok = ~i_lp_mode | (samp_cnt_r < samp_n);
  wire hit = i_smp.vld & (|over) & lp_ok & (s_en | d_en);
  wire [2:0] hit_axis = over[0] ? 3'h1 : over[1] ? 3'h2 : 3'h4;
  wire hit_neg = over[0] ? slp[0][13] : over[1] ? slp[1][13] : slp[2][13];

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      samp_cnt_r <= 5'h0;
    else if (i_wake)
      samp_cnt_r <= 5'h0;
    else if (i_smp.vld && samp_cnt_r != 5'h1F)
      samp_cnt_r <= samp_cnt_r + 5'h1;
  end

  always_comb
  begin
    st_nxt = st_r;
    win_clr = 1'b0;
    s_fire = 1'b0;
    d_fire = 1'b0;
    cap = 1'b0;
    case (st_r)
      T_IDLE:
        if (hit)
        begin
          st_nxt = T_SHOCK;
          win_clr = 1'b1;
          cap = 1'b1;
        end
      T_SHOCK, T_SHOCK2:
        if (win_r >= shock_tk)
        begin
          st_nxt = (st_r == T_SHOCK) ? T_QUIET : T_QUIET2;
          win_clr = 1'b1;
        end
      T_QUIET, T_QUIET2:
        if (hit)
          st_nxt = T_IDLE;
        else if (win_r >= quiet_tk)
        begin
          win_clr = 1'b1;
          if (st_r == T_QUIET)
          begin
            s_fire = 1'b1;
            st_nxt = d_en ? T_GAP : T_IDLE;
          end
          else
          begin
            d_fire = 1'b1;
            st_nxt = T_IDLE;
          end
        end
      T_GAP:
        if (hit)
        begin
          st_nxt = T_SHOCK2;
          win_clr = 1'b1;
        end
        else if (win_r >= gap_tk)
          st_nxt = T_IDLE;
      default:
        st_nxt = T_IDLE;
    endcase
    if (!(s_en | d_en))
      st_nxt = T_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= T_IDLE;
      win_r <= 11'h0;
      pend_axis_r <= 3'h0;
      pend_neg_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (win_clr)
        win_r <= 11'h0;
      else if (tick_r && win_r != 11'h7FF)
        win_r <= win_r + 11'h1;
      if (cap)
      begin
        pend_axis_r <= hit_axis;
        pend_neg_r <= hit_neg;
      end
    end
  end

  wire s_raise = s_fire & s_en;
  wire d_raise = d_fire & d_en;
  wire s_exp = stap_r & tick_r & (stmr_r == 5'h1);
  wire d_exp = dtap_r & tick_r & (dtmr_r == 5'h1);

  // a new raise wins over an expiring timer in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stap_r <= 1'b0;
      dtap_r <= 1'b0;
      stmr_r <= 5'h0;
      dtmr_r <= 5'h0;
      tfirst_r <= 3'h0;
      tsign_r <= 1'b0;
    end
    else
    begin
      if (s_raise)
      begin
        stap_r <= 1'b1;
        stmr_r <= 5'(`CLR_TK);
      end
      else if (stap_r && tick_r)
      begin
        stmr_r <= stmr_r - 5'h1;
        if (s_exp)
          stap_r <= 1'b0;
      end
      if (d_raise)
      begin
        dtap_r <= 1'b1;
        dtmr_r <= 5'(`CLR_TK);
      end
      else if (dtap_r && tick_r)
      begin
        dtmr_r <= dtmr_r - 5'h1;
        if (d_exp)
          dtap_r <= 1'b0;
      end
      if (s_raise | d_raise)
      begin
        tfirst_r <= pend_axis_r;
        tsign_r <= pend_neg_r;
      end
      else if ((s_exp | ~stap_r) & (d_exp | ~dtap_r))
        tfirst_r <= 3'h0;
    end
  end

  // any-motion: level from the slope engine, axis and sign on the rise
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mot_r <= 1'b0;
      mfirst_r <= 3'h0;
      msign_r <= 1'b0;
    end
    else
    begin
      mot_r <= i_mot.act;
      if (i_mot.act && !mot_r)
      begin
        mfirst_r <= (i_mot.axis == 2'h0) ? 3'h1 :
                    (i_mot.axis == 2'h1) ? 3'h2 : 3'h4;
        msign_r <= i_mot.neg;
      end
    end
  end

  // orientation: hysteresis counts shrink as the data LSB grows
  wire [1:0] omode = ocfg_r[`OC_MODE +: 2];
  wire signed [17:0] hy =
    18'(({10'h000, ocfg_r[`OC_HYST +: 3], 8'h00}) >> i_range);
  wire signed [17:0] xs = 18'(i_smp.ax);
  wire signed [17:0] ys = 18'(i_smp.ay);
  wire signed [17:0] absx = xs[17] ? -xs : xs;
  wire signed [17:0] absy = ys[17] ? -ys : ys;
  wire signed [17:0] axs =
    (omode == 2'h1) ? (absx <<< 1) :
    (omode == 2'h2) ? (absx >>> 1) : absx;
  wire port = absy < axs - hy;
  wire land = absy >= axs + hy;
  wire [1:0] xy =
    (port && (xs - hy >= 0)) ? 2'h0 :
    (port && (xs + hy < 0)) ? 2'h1 :
    land ? {1'b1, ~ys[17]} : ori_r[1:0];
  wire [2:0] ori_nxt = {i_smp.az[13], xy};
  wire ori_chg = i_smp.vld & (ori_nxt != ori_r);

  // code moves only on samples, so it simply holds through sleep
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ori_r <= 3'h0;
      ori_int_r <= 1'b0;
    end
    else if (i_smp.vld)
    begin
      ori_r <= ori_nxt;
      ori_int_r <= ori_chg & feat_r[`FE_ORI];
    end
  end

  assign o_motion_int = mot_r;
  assign o_stap_int = stap_r;
  assign o_dtap_int = dtap_r;
  assign o_orient_int = ori_int_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  AST_MOT_ONEHOT: assert property (
    mot_r && !$past(mot_r) |-> $onehot(mfirst_r))
    else $error("motion axis not one-hot");
  AST_MSIGN_HOLD: assert property (
    !(i_mot.act && !mot_r) |=> $stable(msign_r))
    else $error("motion sign changed without trigger");
  AST_SHOCK_IGNORE: assert property (
    st_r == T_SHOCK && win_r < shock_tk && (s_en | d_en)
    |=> st_r == T_SHOCK)
    else $error("shock window left early");
  AST_QUIET_CANCEL: assert property (
    (st_r == T_QUIET || st_r == T_QUIET2) && hit |=> st_r == T_IDLE)
    else $error("quiet violation did not cancel");
  AST_STAP_RAISE: assert property (
    s_raise |=> stap_r && stmr_r == 5'(`CLR_TK))
    else $error("single knock not raised");
  AST_DTAP_RAISE: assert property (
    d_raise |=> dtap_r ##1 dtap_r)
    else $error("double knock not raised");
  AST_TAP_CLEAR: assert property (
    s_exp && !s_raise |=> !stap_r)
    else $error("single knock not cleared");
  AST_TFIRST: assert property (
    (stap_r || dtap_r) ? $onehot(tfirst_r) : tfirst_r == 3'h0)
    else $error("knock axis flags wrong");
  AST_ORI_INT: assert property (
    ori_chg && feat_r[`FE_ORI] |=> ori_int_r && ori_r == $past(ori_nxt))
    else $error("orientation change missed");
  AST_ZBIT: assert property (
    i_smp.vld |=> ori_r[2] == $past(i_smp.az[13]))
    else $error("orientation z bit wrong");
  AST_AVS_ANS: assert property (
    (i_avs_read || i_avs_write) && wait_r |=> !o_avs_waitrequest)
    else $error("bus answer late");

  COV_STAP: cover property (s_raise);
  COV_DTAP: cover property (d_raise);
  COV_CANCEL: cover property (st_r == T_QUIET && hit);
  COV_ORI: cover property (ori_chg && feat_r[`FE_ORI]);
endmodule : motion_tap_orient_engine

// [motion_tap_orient_regs.svh]
`ifndef MOTION_TAP_ORIENT_REGS_SVH
`define MOTION_TAP_ORIENT_REGS_SVH
// register indices; byte address is four times the index
`define REG_STATUS 8'h09
`define REG_DETAIL 8'h0B
`define REG_ORIENT 8'h0C
`define REG_FEAT 8'h16
`define REG_TTIME 8'h2A
`define REG_TTHR 8'h2B
`define REG_OCFG 8'h2C
// status bits
`define ST_MOT 2
`define ST_DTAP 4
`define ST_STAP 5
`define ST_ORI 6
// detail bits
`define DT_MFIRST 0
`define DT_MSIGN 3
`define DT_TFIRST 4
`define DT_TSIGN 7
// feature enable bits
`define FE_DTAP 4
`define FE_STAP 5
`define FE_ORI 6
// knock timing / threshold / orientation fields
`define TT_DUR 0
`define TT_SHOCK 6
`define TT_QUIET 7
`define TH_LVL 0
`define TH_SAMP 6
`define OC_MODE 0
`define OC_HYST 4
// reset values
`define RST_FEAT 8'h00
`define RST_TTIME 8'h00
`define RST_TTHR 8'h0A
`define RST_OCFG 8'h10
// time base
`define CLK_KHZ 40000
`define TICK_US 500
`define TICK_CYC (`CLK_KHZ * `TICK_US / 1000)
`define MS2TK(m) ((m) * 1000 / `TICK_US)
`define SHOCK0_MS 50
`define SHOCK1_MS 75
`define QUIET0_MS 30
`define QUIET1_MS 20
`define CLR_TIME_US 12500
`define CLR_TK (`CLR_TIME_US / `TICK_US)
`define DUR0_MS 50
`define DUR1_MS 100
`define DUR2_MS 150
`define DUR3_MS 200
`define DUR4_MS 250
`define DUR5_MS 375
`define DUR6_MS 500
`define DUR7_MS 700
`endif

// [motion_tap_orient_pkg.sv]
package motion_tap_orient_pkg;
  typedef struct packed {
    logic vld;
    logic signed [13:0] ax;
    logic signed [13:0] ay;
    logic signed [13:0] az;
    logic signed [13:0] sx;
    logic signed [13:0] sy;
    logic signed [13:0] sz;
  } sample_t;
  typedef struct packed {
    logic act;
    logic [1:0] axis;
    logic neg;
  } motion_t;
  typedef enum logic [2:0] {
    T_IDLE, T_SHOCK, T_QUIET, T_GAP, T_SHOCK2, T_QUIET2
  } tap_st_t;
endpackage : motion_tap_orient_pkg

// [tb_top.sv]
`include "motion_tap_orient_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import motion_tap_orient_pkg::*;
  // short tick keeps the windows to a few hundred cycles each
  localparam int TK = 4;
  // last entry sits in the dead band at 2g but not at 4g
  localparam int OM[10] = '{0, 0, 0, 0, 0, 1, 2, 3, 0, 0};
  localparam int OX[10] = '{4000, -4000, 0, 0, 0, 1000, 1500, 1500, 1000,
    800};
  localparam int OY[10] = '{0, 0, -4000, 4000, 4000, 1500, 1100, 1100, 1000,
    1000};
  localparam int OZ[10] = '{1000, 1000, 1000, 1000, -1000, 1000, 1000, 1000,
    1000, 1000};
  localparam int OC[10] = '{0, 1, 2, 3, 7, 0, 3, 0, 0, 3};
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [9:0] i_avs_address = '0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = '0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  sample_t i_smp = '0;
  motion_t i_mot = '0;
  logic [1:0] i_range = 2'h0;
  logic i_lp_mode = 1'b0;
  logic i_wake = 1'b0;
  logic o_motion_int;
  logic o_stap_int;
  logic o_dtap_int;
  logic o_orient_int;
  wire [3:0] ints = {o_orient_int, o_dtap_int, o_stap_int, o_motion_int};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  motion_tap_orient_engine #(.TICK_CYC(TK)) i_dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_smp(i_smp),
    .i_mot(i_mot),
    .i_range(i_range),
    .i_lp_mode(i_lp_mode),
    .i_wake(i_wake),
    .o_motion_int(o_motion_int),
    .o_stap_int(o_stap_int),
    .o_dtap_int(o_dtap_int),
    .o_orient_int(o_orient_int)
  );

  always #12.5 i_clk = ~i_clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // a hang anywhere lands in the closing report
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_write <= w;
    i_avs_read <= ~w;
    i_avs_writedata <= {24'h000000, wd};
    // request stays up until waitrequest is seen low at an edge
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk({24'h000000, d & m}, {24'h000000, e});
  endtask : rdc

  task automatic smp(input logic signed [13:0] ax, ay, az, sx, sy, sz);
    @(posedge i_clk);
    i_smp <= '{1'b1, ax, ay, az, sx, sy, sz};
    @(posedge i_clk);
    i_smp.vld <= 1'b0;
  endtask : smp

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle

  task automatic waitsig(input int w, input int mx, output int c);
    c = 0;
    while (ints[w] !== 1'b1 && c < mx)
    begin
      @(posedge i_clk);
      c++;
    end
  endtask : waitsig

  task automatic wake();
    @(posedge i_clk);
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
  endtask : wake

  task automatic t_reset();
    rdc(`REG_FEAT, 8'hFF, 8'h00);
    rdc(`REG_TTIME, 8'hFF, 8'h00);
    rdc(`REG_TTHR, 8'hFF, 8'h0A);
    rdc(`REG_OCFG, 8'hFF, 8'h10);
    rdc(8'h3F, 8'hFF, 8'h00);
    wr(`REG_STATUS, 8'hFF);
    rdc(`REG_STATUS, 8'hFF, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_motion();
    @(posedge i_clk);
    i_mot <= '{1'b1, 2'd1, 1'b1};
    idle(3);
    chk(o_motion_int, 1'b1);
    rdc(`REG_STATUS, 8'h04, 8'h04);
    rdc(`REG_DETAIL, 8'h0F, 8'h0A);
    i_mot <= '{1'b0, 2'd0, 1'b0};
    idle(3);
    rdc(`REG_DETAIL, 8'h08, 8'h08);
    i_mot <= '{1'b1, 2'd0, 1'b0};
    idle(3);
    rdc(`REG_DETAIL, 8'h0F, 8'h01);
    i_mot <= '{1'b0, 2'd0, 1'b0};
    $display("test motion done");
  endtask : t_motion

  // a second hit inside the shock window must not move the firing time
  task automatic t_single(input logic [7:0] tt, input int ticks);
    int c;
    wr(`REG_FEAT, 8'h20);
    wr(`REG_TTIME, tt);
    wr(`REG_TTHR, 8'h01);
    smp(0, 0, 0, 0, -300, 0);
    idle(20);
    smp(0, 0, 0, 300, 0, 0);
    waitsig(1, ticks * TK + 100, c);
    c = c + 22;
    chk(c >= ticks * TK - TK && c <= ticks * TK + 2 * TK + 4, 1);
    c = 0;
    while (o_stap_int === 1'b1 && c < 400)
    begin
      @(posedge i_clk);
      c++;
    end
    chk(c >= 25 * TK - 2 && c <= 26 * TK + 4, 1);
    rdc(`REG_DETAIL, 8'hF0, 8'h80);
    $display("test single %h done", tt);
  endtask : t_single

  task automatic t_cancel();
    int c;
    wr(`REG_TTIME, 8'h00);
    smp(0, 0, 0, 300, 0, 0);
    idle(100 * TK + 20);
    smp(0, 0, 0, 300, 0, 0);
    waitsig(1, 900, c);
    chk(c, 900);
    idle(200);
    $display("test cancel done");
  endtask : t_cancel

  task automatic t_double();
    int c;
    wr(`REG_FEAT, 8'h10);
    smp(0, 0, 0, 300, 0, 0);
    idle(160 * TK + 100);
    smp(0, 0, 0, 300, 0, 0);
    waitsig(2, 160 * TK + 100, c);
    chk(c >= 160 * TK - TK && c <= 160 * TK + 2 * TK + 4, 1);
    chk(o_stap_int, 1'b0);
    rdc(`REG_STATUS, 8'h30, 8'h10);
    rdc(`REG_DETAIL, 8'hF0, 8'h10);
    idle(200);
    // a second knock after the gap has run out starts a new first event
    smp(0, 0, 0, 300, 0, 0);
    idle(260 * TK + 100);
    smp(0, 0, 0, 300, 0, 0);
    waitsig(2, 900, c);
    chk(c, 900);
    idle(500);
    $display("test double done");
  endtask : t_double

  task automatic t_lp();
    int c;
    wr(`REG_FEAT, 8'h20);
    wr(`REG_TTHR, 8'h01);
    i_lp_mode <= 1'b1;
    wake();
    smp(0, 0, 0, 0, 0, 0);
    smp(0, 0, 0, 0, 0, 0);
    smp(0, 0, 0, 300, 0, 0);
    waitsig(1, 900, c);
    chk(c, 900);
    wake();
    smp(0, 0, 0, 300, 0, 0);
    waitsig(1, 900, c);
    chk(c < 900, 1);
    idle(200);
    i_lp_mode <= 1'b0;
    $display("test lowpower done");
  endtask : t_lp

  task automatic t_orient();
    logic [2:0] prev;
    prev = 3'h0;
    wr(`REG_FEAT, 8'h40);
    for (int i = 0; i < 10; i++)
    begin
      i_range <= (i == 9) ? 2'h1 : 2'h0;
      wr(`REG_OCFG, 8'h10 | 8'(OM[i]));
      smp(14'(OX[i]), 14'(OY[i]), 14'(OZ[i]), 0, 0, 0);
      // the flag is launched at the sampling edge; look one edge later
      idle(1);
      chk(o_orient_int, 32'(OC[i] != prev));
      rdc(`REG_ORIENT, 8'h07, 8'(OC[i]));
      prev = 3'(OC[i]);
    end
    $display("test orient done");
  endtask : t_orient

  initial
  begin
    idle(8);
    i_arst_n <= 1'b1;
    t_reset();
    t_motion();
    t_single(8'h00, 160);
    t_single(8'hC0, 190);
    t_cancel();
    t_double();
    t_lp();
    t_orient();
    summarize();
  end
endmodule : tb_top
